// >>> design/pbm_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the control registers.
// Assumes: One write and one read outstanding at most.
// Notes:   Unmapped offsets answer SLVERR and read zero.
`timescale 1ns/1ps
`include "pbm_params.svh"
module pbm_axil_slave
    import pbm_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    output pbm_wr_t          wr,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data
);
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic        next_w_held;
    logic [7:0]  next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_awready;
    logic        next_wready;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    function automatic logic pbm_mapped(input logic [7:0] a);
        return (a == `PBM_ADDR_BMC) || (a == `PBM_ADDR_STAT);
    endfunction

    assign rd_addr = s_axil_araddr;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axil_bvalid;
        next_bresp   = s_axil_bresp;
        wr.fire      = aw_held && w_held && !s_axil_bvalid;
        wr.addr      = aw_addr;
        wr.data      = w_data;
        wr.strb      = w_strb;
        if (s_axil_awvalid && s_axil_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axil_awaddr;
        end
        if (s_axil_wvalid && s_axil_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axil_wdata;
            next_w_strb = s_axil_wstrb;
        end
        if (s_axil_bvalid && s_axil_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr.fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = pbm_mapped(aw_addr) ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    always_comb begin
        next_rvalid = s_axil_rvalid;
        next_rdata  = s_axil_rdata;
        next_rresp  = s_axil_rresp;
        if (s_axil_rvalid && s_axil_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axil_arvalid && s_axil_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = pbm_mapped(s_axil_araddr) ? rd_data : 32'h00000000;
            next_rresp  = pbm_mapped(s_axil_araddr) ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            aw_addr        <= 8'h00;
            w_data         <= 32'h00000000;
            w_strb         <= 4'h0;
            s_axil_awready <= 1'b0;
            s_axil_wready  <= 1'b0;
            s_axil_bvalid  <= 1'b0;
            s_axil_bresp   <= 2'h0;
            s_axil_arready <= 1'b0;
            s_axil_rvalid  <= 1'b0;
            s_axil_rdata   <= 32'h00000000;
            s_axil_rresp   <= 2'h0;
        end else begin
            aw_held        <= next_aw_held;
            w_held         <= next_w_held;
            aw_addr        <= next_aw_addr;
            w_data         <= next_w_data;
            w_strb         <= next_w_strb;
            s_axil_awready <= next_awready;
            s_axil_wready  <= next_wready;
            s_axil_bvalid  <= next_bvalid;
            s_axil_bresp   <= next_bresp;
            s_axil_arready <= next_arready;
            s_axil_rvalid  <= next_rvalid;
            s_axil_rdata   <= next_rdata;
            s_axil_rresp   <= next_rresp;
        end
    end

endmodule

// >>> design/pbm_col_test.sv
// Purpose: Collision test loop from TX_EN to COL.
// Assumes: tx_en synchronous to aclk.
// Notes:   COL follows TX_EN one cycle later, well inside both limits.
`timescale 1ns/1ps
`include "pbm_params.svh"
module pbm_col_test (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic active,
    input  wire logic tx_en,
    output logic      col
);
    localparam int COL_ON_MAX  = `PBM_COL_ON_CYC;
    localparam int COL_OFF_MAX = `PBM_COL_OFF_CYC;
    // Check window capped at 1000 cycles; still tighter than the allowed limit
    localparam int COL_ON_WIN  = (COL_ON_MAX > 1000) ? 1000 : COL_ON_MAX;

    logic next_col;

    always_comb begin
        next_col = active && tx_en;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            col <= 1'b0;
        end else begin
            col <= next_col;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_tx_start;
        active && $rose(tx_en);
    endsequence

    sequence s_tx_stop;
        $fell(tx_en);
    endsequence

    chk_col_assert: assert property (
        s_tx_start ##1 (active && tx_en) |-> ##[0:COL_ON_WIN] col)
        else $error("COL not raised after TX_EN in collision test");

    chk_col_release: assert property (
        s_tx_stop |-> ##[1:COL_OFF_MAX] !col)
        else $error("COL not released after TX_EN fell");

endmodule

// >>> design/pbm_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          basic mode control block.
// Assumes: 200 MHz aclk, AXI4-Lite register access.
// Notes:   Functional notes follow.
`ifndef PBM_PARAMS_SVH
`define PBM_PARAMS_SVH

`define PBM_ADDR_BMC      8'h00
`define PBM_ADDR_STAT     8'h04

`define PBM_BIT_RESET     15
`define PBM_BIT_LOOP      14
`define PBM_BIT_SPEED     13
`define PBM_BIT_AN_EN     12
`define PBM_BIT_PDOWN     11
`define PBM_BIT_ISO       10
`define PBM_BIT_RESTART   9
`define PBM_BIT_DUPLEX    8
`define PBM_BIT_COLTEST   7

`define PBM_BMC_RESET     16'h0000

`define PBM_RESP_OKAY     2'h0
`define PBM_RESP_SLVERR   2'h2

`define PBM_CLK_NS        5
`define PBM_BIT_NS        10
`define PBM_COL_ON_BITS   512
`define PBM_COL_OFF_BITS  4
`define PBM_COL_ON_CYC    ((`PBM_COL_ON_BITS * `PBM_BIT_NS) / `PBM_CLK_NS)
`define PBM_COL_OFF_CYC   ((`PBM_COL_OFF_BITS * `PBM_BIT_NS) / `PBM_CLK_NS)
`define PBM_SRST_NS       1000
`define PBM_SRST_CYC      ((`PBM_SRST_NS + `PBM_CLK_NS - 1) / `PBM_CLK_NS)

`endif

// >>> design/pbm_pkg.sv
// Purpose: Types shared by the basic mode control block.
// Assumes: Constants live in pbm_params.svh.
// Notes:   Structs carry grouped signals between the modules.
package pbm_pkg;

    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic an_enable;
        logic power_down;
        logic isolate;
        logic restart;
        logic duplex;
        logic col_test;
    } pbm_ctrl_t;

    typedef struct packed {
        logic        fire;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } pbm_wr_t;

    typedef enum logic [1:0] {
        PBM_LOAD,
        PBM_RUN,
        PBM_SRST
    } pbm_state_t;

endpackage

// >>> design/pbm_top.sv
// Purpose: Basic mode control register of one PHY port with its effects.
// Assumes: Negotiation engine acknowledges a restart on an_start_ack.
// Notes:   Straps are sampled on the first cycle after reset release.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pbm_params.svh"
module pbm_top
    import pbm_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    input  wire logic        strap_an_enable,
    input  wire logic        strap_speed_100,
    input  wire logic        strap_full_duplex,
    input  wire logic        power_down_pin_n,
    input  wire logic        an_speed_100,
    input  wire logic        an_full_duplex,
    input  wire logic        an_start_ack,
    input  wire logic        tx_en,
    output logic             an_enable,
    output logic             an_restart,
    output logic             speed_100,
    output logic             full_duplex,
    output logic             power_down,
    output logic             mii_isolate,
    output logic             loopback,
    output logic             col
);
    pbm_wr_t     wr;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    pbm_ctrl_t   ctrl;
    pbm_ctrl_t   next_ctrl;
    pbm_state_t  state;
    pbm_state_t  next_state;
    logic [7:0]  srst_cnt;
    logic [7:0]  next_srst_cnt;
    logic        next_an_enable;
    logic        next_an_restart;
    logic        next_speed_100;
    logic        next_full_duplex;
    logic        next_power_down;
    logic        next_mii_isolate;
    logic        next_loopback;
    logic        col_active;
    logic        bmc_wr;
    logic [15:0] bmc_rd;
    logic [15:0] stat_rd;

    pbm_axil_slave u_slave (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .s_axil_awaddr  (s_axil_awaddr),
        .s_axil_awvalid (s_axil_awvalid),
        .s_axil_awready (s_axil_awready),
        .s_axil_wdata   (s_axil_wdata),
        .s_axil_wstrb   (s_axil_wstrb),
        .s_axil_wvalid  (s_axil_wvalid),
        .s_axil_wready  (s_axil_wready),
        .s_axil_bresp   (s_axil_bresp),
        .s_axil_bvalid  (s_axil_bvalid),
        .s_axil_bready  (s_axil_bready),
        .s_axil_araddr  (s_axil_araddr),
        .s_axil_arvalid (s_axil_arvalid),
        .s_axil_arready (s_axil_arready),
        .s_axil_rdata   (s_axil_rdata),
        .s_axil_rresp   (s_axil_rresp),
        .s_axil_rvalid  (s_axil_rvalid),
        .s_axil_rready  (s_axil_rready),
        .wr             (wr),
        .rd_addr        (rd_addr),
        .rd_data        (rd_data)
    );

    assign bmc_wr = wr.fire && (wr.addr == `PBM_ADDR_BMC);

    // Read view of the control word; low seven bits are always zero
    always_comb begin
        bmc_rd                    = `PBM_BMC_RESET;
        bmc_rd[`PBM_BIT_RESET]    = (state != PBM_RUN);
        bmc_rd[`PBM_BIT_LOOP]     = ctrl.loopback;
        bmc_rd[`PBM_BIT_SPEED]    = ctrl.speed_100;
        bmc_rd[`PBM_BIT_AN_EN]    = ctrl.an_enable;
        bmc_rd[`PBM_BIT_PDOWN]    = ctrl.power_down || !power_down_pin_n;
        bmc_rd[`PBM_BIT_ISO]      = ctrl.isolate;
        bmc_rd[`PBM_BIT_RESTART]  = ctrl.restart;
        bmc_rd[`PBM_BIT_DUPLEX]   = ctrl.duplex;
        bmc_rd[`PBM_BIT_COLTEST]  = ctrl.col_test;
    end

    // Status word: effective port state
    always_comb begin
        stat_rd    = 16'h0000;
        stat_rd[0] = speed_100;
        stat_rd[1] = full_duplex;
        stat_rd[2] = power_down;
        stat_rd[3] = mii_isolate;
        stat_rd[4] = (state != PBM_RUN);
        stat_rd[5] = an_restart;
        stat_rd[6] = !power_down_pin_n;
    end

    always_comb begin
        rd_data = 32'h00000000;
        if (rd_addr == `PBM_ADDR_BMC) begin
            rd_data[15:0] = bmc_rd;
        end else if (rd_addr == `PBM_ADDR_STAT) begin
            rd_data[15:0] = stat_rd;
        end
    end

    // Control word, strap loading and software reset sequencing
    always_comb begin
        next_ctrl     = ctrl;
        next_state    = state;
        next_srst_cnt = srst_cnt;
        if (ctrl.restart && an_start_ack) begin
            next_ctrl.restart = 1'b0;
        end
        case (state)
            PBM_LOAD: begin
                next_ctrl           = '0;
                next_ctrl.an_enable = strap_an_enable;
                next_ctrl.speed_100 = strap_speed_100;
                next_ctrl.duplex    = strap_full_duplex;
                next_state          = PBM_RUN;
            end
            PBM_SRST: begin
                next_srst_cnt = srst_cnt - 8'h01;
                if (srst_cnt == 8'h00) begin
                    next_state = PBM_LOAD;
                end
            end
            PBM_RUN: begin
                if (bmc_wr && wr.strb[1]) begin
                    next_ctrl.loopback   = wr.data[`PBM_BIT_LOOP];
                    next_ctrl.speed_100  = wr.data[`PBM_BIT_SPEED];
                    next_ctrl.an_enable  = wr.data[`PBM_BIT_AN_EN];
                    next_ctrl.power_down = wr.data[`PBM_BIT_PDOWN];
                    next_ctrl.isolate    = wr.data[`PBM_BIT_ISO];
                    next_ctrl.duplex     = wr.data[`PBM_BIT_DUPLEX];
                    // A new restart wins over a same-cycle acknowledge
                    if (wr.data[`PBM_BIT_RESTART] && wr.data[`PBM_BIT_AN_EN]) begin
                        next_ctrl.restart = 1'b1;
                    end
                    if (wr.data[`PBM_BIT_RESET]) begin
                        next_state    = PBM_SRST;
                        next_srst_cnt = 8'(`PBM_SRST_CYC - 1);
                    end
                end
                if (bmc_wr && wr.strb[0]) begin
                    next_ctrl.col_test = wr.data[`PBM_BIT_COLTEST];
                end
            end
            default: begin
                next_state = PBM_LOAD;
            end
        endcase
        if (!next_ctrl.an_enable) begin
            next_ctrl.restart = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl     <= '0;
            state    <= PBM_LOAD;
            srst_cnt <= 8'h00;
        end else begin
            ctrl     <= next_ctrl;
            state    <= next_state;
            srst_cnt <= next_srst_cnt;
        end
    end

    // Effective port controls, registered toward the datapath
    always_comb begin
        next_an_enable   = next_ctrl.an_enable;
        next_power_down  = next_ctrl.power_down || !power_down_pin_n;
        next_mii_isolate = next_ctrl.isolate;
        next_loopback    = next_ctrl.loopback;
        next_an_restart  = next_ctrl.restart && !next_power_down;
        if (next_ctrl.an_enable) begin
            next_speed_100   = an_speed_100;
            next_full_duplex = an_full_duplex;
        end else begin
            next_speed_100   = next_ctrl.speed_100;
            next_full_duplex = next_ctrl.duplex;
        end
        col_active = next_ctrl.col_test && !next_power_down && !next_ctrl.isolate;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            an_enable   <= 1'b0;
            an_restart  <= 1'b0;
            speed_100   <= 1'b0;
            full_duplex <= 1'b0;
            power_down  <= 1'b0;
            mii_isolate <= 1'b0;
            loopback    <= 1'b0;
        end else begin
            an_enable   <= next_an_enable;
            an_restart  <= next_an_restart;
            speed_100   <= next_speed_100;
            full_duplex <= next_full_duplex;
            power_down  <= next_power_down;
            mii_isolate <= next_mii_isolate;
            loopback    <= next_loopback;
        end
    end

    pbm_col_test u_col (
        .aclk    (aclk),
        .aresetn (aresetn),
        .active  (col_active),
        .tx_en   (tx_en),
        .col     (col)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_restart_pending;
        ctrl.restart && !an_start_ack && (state == PBM_RUN) && !bmc_wr;
    endsequence

    sequence s_restart_refused;
        bmc_wr && wr.strb[1] && wr.data[`PBM_BIT_RESTART]
            && !wr.data[`PBM_BIT_AN_EN] && (state == PBM_RUN);
    endsequence

    chk_an_ignores_bits: assert property (
        ##1 an_enable |-> speed_100 == $past(an_speed_100)
            && full_duplex == $past(an_full_duplex))
        else $error("Negotiated mode not followed while enabled");

    chk_forced_mode: assert property (
        !an_enable |-> speed_100 == ctrl.speed_100 && full_duplex == ctrl.duplex)
        else $error("Forced speed or duplex not applied");

    chk_pin_power_down: assert property (
        !power_down_pin_n |-> bmc_rd[`PBM_BIT_PDOWN] ##1 power_down)
        else $error("Power-down pin not reflected");

    chk_pd_quiet: assert property (
        (power_down || mii_isolate) |-> !col && !(power_down && an_restart))
        else $error("Activity while powered down or isolated");

    chk_restart_ignored: assert property (
        s_restart_refused |=> !ctrl.restart)
        else $error("Restart taken while negotiation disabled");

    chk_restart_hold: assert property (
        s_restart_pending |=> ctrl.restart)
        else $error("Restart bit cleared before negotiation started");

    chk_reserved_zero: assert property (
        ##1 s_axil_rvalid && $rose(s_axil_rvalid)
            && $past(rd_addr == `PBM_ADDR_BMC) |-> s_axil_rdata[6:0] == 7'h00)
        else $error("Reserved control bits read nonzero");

    chk_srst_reload: assert property (
        (state == PBM_LOAD) ##1 (state == PBM_RUN) |-> ctrl.an_enable == $past(strap_an_enable)
            && ctrl.speed_100 == $past(strap_speed_100) && !ctrl.power_down)
        else $error("Straps not reloaded after reset");

    chk_srst_busy: assert property (
        (state == PBM_RUN) ##1 (state == PBM_SRST) |-> bmc_rd[`PBM_BIT_RESET] [*8])
        else $error("Reset bit not held during reset");

endmodule

// >>> tb/pbm_an_model.sv
// Purpose: Behavioural negotiation engine facing the control block.
// Assumes: Restart request is a level held until the start is seen.
// Notes:   delay picks a prompt or a slow start report.
`timescale 1ns/1ps
module pbm_an_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       an_restart,
    input  wire logic [4:0] delay,
    output logic            an_start_ack
);
    logic [4:0] cnt;
    // One start report per request for delays below 31, after the chosen delay
    always_ff @(posedge aclk) begin
        if (!aresetn || !an_restart) begin
            cnt          <= 5'h00;
            an_start_ack <= 1'b0;
        end else begin
            cnt          <= (cnt == 5'h1F) ? cnt : cnt + 5'h01;
            an_start_ack <= (cnt == delay);
        end
    end
endmodule

// >>> tb/test_phy_basic_mode_control.sv
// Purpose: Self-checking bench for the basic mode control block.
// Assumes: 200 MHz aclk, fixed seed, AXI4-Lite master tasks.
// Notes:   Negotiation engine is modelled in pbm_an_model.
`timescale 1ns/1ps
`include "pbm_params.svh"
module test_phy_basic_mode_control import pbm_pkg::*; ;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, s_an, s_sp, s_fd, pin_n, an_sp, an_fd;
    logic        ack, tx_en, an_en, an_rst, sp, fd, pd, iso, lb, col;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [4:0]  dly;
    int          num_errors, num_checks;
    pbm_top pbm_top_i (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
        .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
        .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
        .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .strap_an_enable(s_an), .strap_speed_100(s_sp),
        .strap_full_duplex(s_fd), .power_down_pin_n(pin_n), .an_speed_100(an_sp),
        .an_full_duplex(an_fd), .an_start_ack(ack), .tx_en(tx_en), .an_enable(an_en),
        .an_restart(an_rst), .speed_100(sp), .full_duplex(fd), .power_down(pd),
        .mii_isolate(iso), .loopback(lb), .col(col));
    pbm_an_model pbm_an_model_i (.aclk(aclk), .aresetn(aresetn), .an_restart(an_rst),
        .delay(dly), .an_start_ack(ack));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r  = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tb;
        tb = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tb = rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(`PBM_ADDR_BMC, d, r);
        chk(d, {16'h0000, e});
        chk(r, `PBM_RESP_OKAY);
    endtask
    // Register image right after a strap load
    function automatic logic [15:0] strap_bmc();
        return {2'b00, s_sp, s_an, 3'b000, s_fd, 8'h00};
    endfunction
    task automatic chk_out(input logic [15:0] d);
        chk(an_en, d[12]);
        chk(sp, d[12] ? an_sp : d[13]);
        chk(fd, d[12] ? an_fd : d[8]);
        chk(pd, d[11]);
        chk(iso, d[10]);
        chk(lb, d[14]);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] v;
        int          i;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, tx_en} = 7'h00;
        {awaddr, araddr, wdata, wstrb, pin_n, dly} = {16'h0000, 32'h0, 4'h3, 1'b1, 5'h1E};
        void'($urandom(32'h21B7BC86));
        v = 16'($urandom);
        {s_an, s_sp, s_fd, an_sp, an_fd} = v[4:0];
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rdc(strap_bmc());
        chk_out(strap_bmc());
        for (i = 0; i < 12; i++) begin
            v = 16'($urandom);
            v[15] = 1'b0;
            v[9] = 1'b0;
            if (i == 0) v[11:7] = 5'b00001;
            {an_sp, an_fd} <= 2'($urandom);
            wr(`PBM_ADDR_BMC, v, r);
            chk(r, `PBM_RESP_OKAY);
            rdc(v & 16'h7D80);
            chk_out(v);
            tx_en <= 1'b1;
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            chk(col, v[7] & !v[11] & !v[10]);
            @(posedge aclk) tx_en <= 1'b0;
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            chk(col, 1'b0);
        end
        wr(`PBM_ADDR_BMC, 16'h0000, r);
        pin_n <= 1'b0;
        rdc(16'h0800);
        chk(pd, 1'b1);
        rd(`PBM_ADDR_STAT, d, r);
        chk(d, 32'h0000_0044);
        chk(r, `PBM_RESP_OKAY);
        pin_n <= 1'b1;
        wr(`PBM_ADDR_BMC, 16'h1200, r);
        rdc(16'h1200);
        chk(an_rst, 1'b1);
        wr(`PBM_ADDR_BMC, 16'h1000, r);
        rdc(16'h1200);
        i = 0;
        // Manager polls until the start has been seen
        do begin
            rd(`PBM_ADDR_BMC, d, r);
            i++;
        end while (d[9] && i < 20);
        chk(d, 32'h0000_1000);
        wr(`PBM_ADDR_BMC, 16'h0200, r);
        rdc(16'h0000);
        chk(an_rst, 1'b0);
        v = 16'($urandom);
        {s_an, s_sp, s_fd} <= v[2:0];
        wr(`PBM_ADDR_BMC, 16'h8000, r);
        rdc(16'h8000);
        repeat (250) @(posedge aclk);
        rdc(strap_bmc());
        wr(8'h08, 16'hFFFF, r);
        chk(r, `PBM_RESP_SLVERR);
        rd(8'h08, d, r);
        chk(d, 32'h0);
        chk(r, `PBM_RESP_SLVERR);
        end_of_test();
    end
endmodule
